// [logic/ahb_reg_slave.sv]
// AHB-Lite slave with no wait states for byte-wide registers on word slots.
// Assumes single word transfers; other sizes are treated as words.
`timescale 1ns/1ps
module ahb_reg_slave
  import buck_cfg_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  reg_access_if.slave            regs
);

  logic        accept;
  logic        idx_ok;
  logic        wr_pend_d, wr_pend_q;
  logic [7:0]  wr_idx_d, wr_idx_q;
  logic [31:0] rdata_d, rdata_q;
  logic [2:0]  size_seen;

  // Size is not checked: only whole words are ever issued
  assign size_seen = hsize;
  assign accept    = hsel && htrans[1] && hreadyout;
  assign idx_ok    = (haddr[ADDR_W-1:10] == 2'h0) && (haddr[1:0] == 2'h0);

  assign regs.rd_idx  = haddr[9:2];
  assign regs.wr_en   = wr_pend_q;
  assign regs.wr_idx  = wr_idx_q;
  assign regs.wr_data = hwdata[7:0];

  always_comb
  begin
    wr_pend_d = accept && hwrite && idx_ok;
    wr_idx_d  = accept ? haddr[9:2] : wr_idx_q;
    rdata_d   = rdata_q;
    if (accept && !hwrite)
    begin
      rdata_d = 32'h0000_0000;
      // The bank answers with next-state values, so a write still in its
      // data phase is seen already masked, as the register will hold it
      if (idx_ok)
        rdata_d[7:0] = regs.rd_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q  <= wr_idx_d;
      rdata_q   <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : ahb_reg_slave

// [logic/buck_cfg_pkg.sv]
// Constants for the step-down converter configuration bank: register
// indices, field positions, reset values and mode encodings.
// Assumes byte addresses on the register bus are four times the index.
package buck_cfg_pkg;

  localparam int          NUM_CONV        = 3;
  localparam int          CONV_CORE_ONE   = 0;
  localparam int          CONV_CORE_TWO   = 1;
  localparam int          CONV_GENERAL    = 2;

  localparam int          ADDR_W          = 12;
  localparam logic [7:0]  IDX_CURRENT_LIM = 8'h9c;
  localparam logic [7:0]  IDX_CORE_TWO    = 8'h9d;
  localparam logic [7:0]  IDX_CORE_ONE    = 8'h9e;
  localparam logic [7:0]  IDX_GENERAL     = 8'h9f;
  localparam logic [7:0]  IDX_STATUS      = 8'hc0;

  localparam logic [7:0]  RST_CURRENT_LIM = 8'h00;
  localparam logic [7:0]  RST_CONFIG      = 8'h01;
  localparam logic [7:0]  CORE_RSVD_MASK  = 8'h18;

  localparam int          ILIM_TWO_LSB    = 4;
  localparam int          ILIM_ONE_LSB    = 0;
  localparam int          MODE_LSB        = 6;
  localparam int          PD_OFF_BIT      = 5;
  localparam int          TERM_MODE_BIT   = 4;
  localparam int          TERM_REF_BIT    = 3;
  localparam int          FB_LSB          = 0;

  localparam int          ST_FB_INV_LSB   = 0;
  localparam int          ST_TERM_ERR     = 3;
  localparam int          ST_FULL_CUR     = 4;
  localparam int          ST_DUAL_PHASE   = 5;
  localparam int          ST_MERGE        = 6;

  localparam logic [11:0] ILIM_BASE_MA    = 12'h1f4;
  localparam logic [11:0] ILIM_STEP_MA    = 12'h064;

  localparam logic [1:0]  POLICY_AB       = 2'h0;
  localparam logic [1:0]  POLICY_SLEEP    = 2'h1;
  localparam logic [1:0]  POLICY_SYNC     = 2'h2;
  localparam logic [1:0]  POLICY_AUTO     = 2'h3;

  localparam logic [1:0]  OP_SYNC         = 2'h0;
  localparam logic [1:0]  OP_SLEEP        = 2'h1;
  localparam logic [1:0]  OP_AUTO         = 2'h2;

endpackage : buck_cfg_pkg

// [logic/buck_core_pro_config_regs.sv]
// Configuration register bank for two core step-down converters and one
// general converter usable as a memory termination supply.
// Assumes an AHB-Lite master on sys_clk and synchronous status inputs.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module buck_core_pro_config_regs
  import buck_cfg_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  input  wire logic                         hsel,
  input  wire logic [ADDR_W-1:0]            haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic                         full_current_active,
  input  wire logic                         dual_phase_active,
  input  wire logic                         core_pair_merge,
  input  wire logic [NUM_CONV-1:0]          sleep_select_a,
  input  wire logic [NUM_CONV-1:0]          conv_enabled,
  output logic      [11:0]                  core_one_current_limit_ma,
  output logic      [11:0]                  core_two_current_limit_ma,
  output logic      [NUM_CONV-1:0][1:0]     conv_op_mode,
  output logic      [NUM_CONV-1:0]          conv_pulldown_on,
  output logic      [NUM_CONV-1:0][2:0]     conv_sense_mix,
  output logic      [NUM_CONV-1:0]          conv_feedback_invalid,
  output logic                              core_one_mixer_off,
  output logic                              core_one_remote_diff_sense,
  output logic                              termination_mode_on,
  output logic                              termination_reference_on,
  output logic                              reference_port_comparator,
  output logic                              memory_sense_reports_input
);

  reg_access_if regs ();

  ahb_reg_slave u_slave (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regs      (regs)
  );

  // Register storage
  logic [7:0] current_limits_d, current_limits_q;
  logic [7:0] core_two_config_d, core_two_config_q;
  logic [7:0] core_one_config_d, core_one_config_q;
  logic [7:0] general_config_d, general_config_q;
  logic [7:0] status_view;

  function automatic logic [11:0] limit_ma(input logic [3:0] code, input logic full);
    logic [11:0] base;
    base = ILIM_BASE_MA + ({8'h00, code} * ILIM_STEP_MA);
    return full ? {base[10:0], 1'b0} : base;
  endfunction : limit_ma

  function automatic logic wr_hit(input logic [7:0] idx);
    return regs.wr_en && (regs.wr_idx == idx);
  endfunction : wr_hit

  always_comb
  begin
    current_limits_d  = current_limits_q;
    core_two_config_d = core_two_config_q;
    core_one_config_d = core_one_config_q;
    general_config_d  = general_config_q;
    if (wr_hit(IDX_CURRENT_LIM))
      current_limits_d = regs.wr_data;
    if (wr_hit(IDX_CORE_TWO))
      core_two_config_d = regs.wr_data & ~CORE_RSVD_MASK;
    if (wr_hit(IDX_CORE_ONE))
      core_one_config_d = regs.wr_data & ~CORE_RSVD_MASK;
    if (wr_hit(IDX_GENERAL))
      general_config_d = regs.wr_data;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      current_limits_q  <= RST_CURRENT_LIM;
      core_two_config_q <= RST_CONFIG;
      core_one_config_q <= RST_CONFIG;
      general_config_q  <= RST_CONFIG;
    end
    else
    begin
      current_limits_q  <= current_limits_d;
      core_two_config_q <= core_two_config_d;
      core_one_config_q <= core_one_config_d;
      general_config_q  <= general_config_d;
    end
  end

  // Per-converter field views, indexed by converter number
  logic [NUM_CONV-1:0][7:0] conv_cfg;
  logic [NUM_CONV-1:0]      pd_inhibit;
  logic [NUM_CONV-1:0][1:0] op_mode_w;
  logic [NUM_CONV-1:0]      pd_on_w;
  logic [NUM_CONV-1:0][2:0] sense_w;
  logic [NUM_CONV-1:0]      fb_inv_w;

  assign conv_cfg[CONV_CORE_ONE]   = core_one_config_q;
  assign conv_cfg[CONV_CORE_TWO]   = core_two_config_q;
  assign conv_cfg[CONV_GENERAL]    = general_config_q;
  // Paralleled phases must not discharge each other's output
  assign pd_inhibit[CONV_CORE_ONE] = 1'b0;
  assign pd_inhibit[CONV_CORE_TWO] = dual_phase_active;
  assign pd_inhibit[CONV_GENERAL]  = 1'b0;

  generate
    for (genvar c = 0; c < NUM_CONV; c++)
    begin : g_conv
      // Only core one treats an all-zero sense field as a legal setting
      converter_policy #(
        .ZERO_FB_VALID (c == CONV_CORE_ONE)
      ) u_policy (
        .mode_policy      (conv_cfg[c][MODE_LSB+:2]),
        .sleep_select_a   (sleep_select_a[c]),
        .pulldown_off     (conv_cfg[c][PD_OFF_BIT]),
        .conv_enabled     (conv_enabled[c]),
        .pulldown_inhibit (pd_inhibit[c]),
        .feedback_select  (conv_cfg[c][FB_LSB+:3]),
        .op_mode          (op_mode_w[c]),
        .pulldown_on      (pd_on_w[c]),
        .sense_mix        (sense_w[c]),
        .feedback_invalid (fb_inv_w[c])
      );
    end
  endgenerate

  // Output stage: every output but the tied-off hreadyout and hresp leaves from a flip-flop
  logic [11:0]              one_lim_d, one_lim_q;
  logic [11:0]              two_lim_d, two_lim_q;
  logic [NUM_CONV-1:0][1:0] op_mode_d, op_mode_q;
  logic [NUM_CONV-1:0]      pd_on_d, pd_on_q;
  logic [NUM_CONV-1:0][2:0] sense_d, sense_q;
  logic [NUM_CONV-1:0]      fb_inv_d, fb_inv_q;
  logic                     mixer_off_d, mixer_off_q;
  logic                     remote_diff_d, remote_diff_q;
  logic                     term_mode_d, term_mode_q;
  logic                     term_ref_d, term_ref_q;
  logic                     ref_cmp_d, ref_cmp_q;
  logic                     mem_in_d, mem_in_q;
  logic                     term_err;
  logic                     core_one_fb_zero;

  assign core_one_fb_zero = (core_one_config_q[FB_LSB+:3] == 3'h0);
  // Termination without the reference enable cannot track; flagged, not blocked
  assign term_err = general_config_q[TERM_MODE_BIT] && !general_config_q[TERM_REF_BIT];

  always_comb
  begin
    one_lim_d     = limit_ma(current_limits_q[ILIM_ONE_LSB+:4], full_current_active);
    two_lim_d     = limit_ma(current_limits_q[ILIM_TWO_LSB+:4], full_current_active);
    op_mode_d     = op_mode_w;
    pd_on_d       = pd_on_w;
    sense_d       = sense_w;
    fb_inv_d      = fb_inv_w;
    mixer_off_d   = core_one_fb_zero;
    remote_diff_d = core_one_fb_zero && core_pair_merge;
    term_mode_d   = general_config_q[TERM_MODE_BIT];
    term_ref_d    = general_config_q[TERM_REF_BIT];
    ref_cmp_d     = !general_config_q[TERM_REF_BIT];
    mem_in_d      = !general_config_q[TERM_REF_BIT];
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      one_lim_q     <= 12'h000;
      two_lim_q     <= 12'h000;
      op_mode_q     <= '0;
      pd_on_q       <= '0;
      sense_q       <= '0;
      fb_inv_q      <= '0;
      mixer_off_q   <= 1'b0;
      remote_diff_q <= 1'b0;
      term_mode_q   <= 1'b0;
      term_ref_q    <= 1'b0;
      // Reference port falls back to the comparator while held in reset
      ref_cmp_q     <= 1'b1;
      mem_in_q      <= 1'b1;
    end
    else
    begin
      one_lim_q     <= one_lim_d;
      two_lim_q     <= two_lim_d;
      op_mode_q     <= op_mode_d;
      pd_on_q       <= pd_on_d;
      sense_q       <= sense_d;
      fb_inv_q      <= fb_inv_d;
      mixer_off_q   <= mixer_off_d;
      remote_diff_q <= remote_diff_d;
      term_mode_q   <= term_mode_d;
      term_ref_q    <= term_ref_d;
      ref_cmp_q     <= ref_cmp_d;
      mem_in_q      <= mem_in_d;
    end
  end

  assign core_one_current_limit_ma  = one_lim_q;
  assign core_two_current_limit_ma  = two_lim_q;
  assign conv_op_mode               = op_mode_q;
  assign conv_pulldown_on           = pd_on_q;
  assign conv_sense_mix             = sense_q;
  assign conv_feedback_invalid      = fb_inv_q;
  assign core_one_mixer_off         = mixer_off_q;
  assign core_one_remote_diff_sense = remote_diff_q;
  assign termination_mode_on        = term_mode_q;
  assign termination_reference_on   = term_ref_q;
  assign reference_port_comparator  = ref_cmp_q;
  assign memory_sense_reports_input = mem_in_q;

  // Read mux; status shows live block state, unmapped slots read zero
  always_comb
  begin
    status_view                           = 8'h00;
    status_view[ST_FB_INV_LSB+:NUM_CONV]  = fb_inv_w;
    status_view[ST_TERM_ERR]              = term_err;
    status_view[ST_FULL_CUR]              = full_current_active;
    status_view[ST_DUAL_PHASE]            = dual_phase_active;
    status_view[ST_MERGE]                 = core_pair_merge;
    case (regs.rd_idx)
      // Next-state values: a read right behind a write returns the stored form
      IDX_CURRENT_LIM: regs.rd_data = current_limits_d;
      IDX_CORE_TWO:    regs.rd_data = core_two_config_d;
      IDX_CORE_ONE:    regs.rd_data = core_one_config_d;
      IDX_GENERAL:     regs.rd_data = general_config_d;
      IDX_STATUS:      regs.rd_data = status_view;
      default:         regs.rd_data = 8'h00;
    endcase
  end

endmodule : buck_core_pro_config_regs

// [logic/converter_policy.sv]
// Resolves one converter's mode policy, discharge pull-down and sense mix.
// Assumes all inputs are synchronous levels; purely combinational.
`timescale 1ns/1ps
module converter_policy
  import buck_cfg_pkg::*;
#(
  parameter bit ZERO_FB_VALID = 1'b0
)
(
  input  wire logic [1:0] mode_policy,
  input  wire logic       sleep_select_a,
  input  wire logic       pulldown_off,
  input  wire logic       conv_enabled,
  input  wire logic       pulldown_inhibit,
  input  wire logic [2:0] feedback_select,
  output logic      [1:0] op_mode,
  output logic            pulldown_on,
  output logic      [2:0] sense_mix,
  output logic            feedback_invalid
);

  always_comb
  begin
    case (mode_policy)
      POLICY_AB:    op_mode = sleep_select_a ? OP_SLEEP : OP_SYNC;
      POLICY_SLEEP: op_mode = OP_SLEEP;
      POLICY_SYNC:  op_mode = OP_SYNC;
      POLICY_AUTO:  op_mode = OP_AUTO;
      default:      op_mode = OP_SYNC;
    endcase
  end

  // Discharge only acts while the converter is off
  assign pulldown_on      = !conv_enabled && !pulldown_off && !pulldown_inhibit;
  assign sense_mix        = feedback_select;
  assign feedback_invalid = (feedback_select == 3'h0) && !ZERO_FB_VALID;

endmodule : converter_policy

// [logic/reg_access_if.sv]
// Carries register writes and read lookups from the bus slave to the bank.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
interface reg_access_if;
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;

  modport slave (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport bank  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : reg_access_if

// [verif/buck_cfg_asserts.sv]
// Concurrent checks on the converter configuration bank's ports.
// Assumes outputs follow their register or input cause by one clock.
`timescale 1ns/1ps
module buck_cfg_asserts
  import buck_cfg_pkg::*;
(
  input wire logic                     sys_clk,
  input wire logic                     arst_n,
  input wire logic                     full_current_active,
  input wire logic                     dual_phase_active,
  input wire logic                     core_pair_merge,
  input wire logic [NUM_CONV-1:0]      conv_enabled,
  input wire logic [11:0]              core_one_current_limit_ma,
  input wire logic [11:0]              core_two_current_limit_ma,
  input wire logic [NUM_CONV-1:0]      conv_pulldown_on,
  input wire logic [NUM_CONV-1:0][2:0] conv_sense_mix,
  input wire logic [NUM_CONV-1:0]      conv_feedback_invalid,
  input wire logic                     core_one_mixer_off,
  input wire logic                     core_one_remote_diff_sense,
  input wire logic                     termination_reference_on,
  input wire logic                     reference_port_comparator,
  input wire logic                     memory_sense_reports_input
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Outputs may still hold reset zeros on the first edges after release
  logic [1:0] up_q;
  logic [1:0] up_d;
  always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) up_q <= 2'h0;
    else up_q <= up_d;

  function automatic bit lim_ok(input logic [11:0] ma, input logic f);
    logic [11:0] b;
    b = f ? (ma >> 1) : ma;
    return (!f || !ma[0]) && b >= 12'h1f4 && b <= 12'h7d0 && (b % 12'h064) == 12'h0;
  endfunction : lim_ok

  property p_lim_two;
    up_q == 2'h3 |-> lim_ok(core_two_current_limit_ma, $past(full_current_active));
  endproperty
  a_lim_two: assert property (p_lim_two) else $error("core two limit off scale");
  property p_lim_one;
    up_q == 2'h3 |-> lim_ok(core_one_current_limit_ma, $past(full_current_active));
  endproperty
  a_lim_one: assert property (p_lim_one) else $error("core one limit off scale");
  property p_pd_two;
    conv_pulldown_on[1] |-> !$past(dual_phase_active) && !$past(conv_enabled[1]);
  endproperty
  a_pd_two: assert property (p_pd_two) else $error("core two pull-down wrongly on");
  property p_pd_one;
    up_q == 2'h3 |-> (!conv_pulldown_on[0] || !$past(conv_enabled[0]))
      && (!conv_pulldown_on[2] || !$past(conv_enabled[2]));
  endproperty
  a_pd_one: assert property (p_pd_one) else $error("pull-down on while enabled");
  property p_fb_two;
    up_q == 2'h3 |-> conv_feedback_invalid[1] == (conv_sense_mix[1] == 3'h0);
  endproperty
  a_fb_two: assert property (p_fb_two) else $error("core two invalid flag wrong");
  property p_fb_gen;
    up_q == 2'h3 |-> conv_feedback_invalid[2] == (conv_sense_mix[2] == 3'h0);
  endproperty
  a_fb_gen: assert property (p_fb_gen) else $error("general invalid flag wrong");
  property p_fb_one;
    up_q == 2'h3 |-> !conv_feedback_invalid[0]
      && core_one_mixer_off == (conv_sense_mix[0] == 3'h0);
  endproperty
  a_fb_one: assert property (p_fb_one) else $error("core one mixer flag wrong");
  property p_diff;
    up_q == 2'h3 |-> core_one_remote_diff_sense == (core_one_mixer_off && $past(core_pair_merge));
  endproperty
  a_diff: assert property (p_diff) else $error("remote sense flag wrong");
  property p_ref;
    reference_port_comparator == !termination_reference_on
      && memory_sense_reports_input == reference_port_comparator;
  endproperty
  a_ref: assert property (p_ref) else $error("reference port routing wrong");
endmodule : buck_cfg_asserts

bind buck_core_pro_config_regs buck_cfg_asserts u_chk (.sys_clk, .arst_n,
  .full_current_active, .dual_phase_active, .core_pair_merge, .conv_enabled,
  .core_one_current_limit_ma, .core_two_current_limit_ma, .conv_pulldown_on,
  .conv_sense_mix, .conv_feedback_invalid, .core_one_mixer_off,
  .core_one_remote_diff_sense, .termination_reference_on,
  .reference_port_comparator, .memory_sense_reports_input);

// [verif/testbench.sv]
// Self-checking bench for the converter configuration bank.
// Assumes a zero-wait AHB-Lite slave and outputs one clock behind causes.
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e));
module testbench;
  import buck_cfg_pkg::*;
  logic                     sys_clk = 1'b0;
  logic                     arst_n = 1'b0;
  logic                     hsel = 1'b0;
  logic                     hwrite = 1'b0;
  logic [ADDR_W-1:0]        haddr = '0;
  logic [1:0]               htrans = 2'h0;
  logic [2:0]               hsize = 3'h2;
  logic [31:0]              hwdata = 32'h0;
  logic                     full_current_active = 1'b0;
  logic                     dual_phase_active = 1'b0;
  logic                     core_pair_merge = 1'b0;
  logic [NUM_CONV-1:0]      sleep_select_a = 3'h0;
  logic [NUM_CONV-1:0]      conv_enabled = 3'h0;
  logic [31:0]              hrdata;
  logic                     hreadyout;
  logic                     hresp;
  logic [11:0]              core_one_current_limit_ma;
  logic [11:0]              core_two_current_limit_ma;
  logic [NUM_CONV-1:0][1:0] conv_op_mode;
  logic [NUM_CONV-1:0]      conv_pulldown_on;
  logic [NUM_CONV-1:0][2:0] conv_sense_mix;
  logic [NUM_CONV-1:0]      conv_feedback_invalid;
  logic                     core_one_mixer_off;
  logic                     core_one_remote_diff_sense;
  logic                     termination_mode_on;
  logic                     termination_reference_on;
  logic                     reference_port_comparator;
  logic                     memory_sense_reports_input;
  logic [31:0]              rd;
  int                       errors = 0;
  int                       total_checks = 0;
  int                       cycles = 0;

  buck_core_pro_config_regs dut (.sys_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hrdata, .hreadyout, .hresp, .full_current_active,
    .dual_phase_active, .core_pair_merge, .sleep_select_a, .conv_enabled,
    .core_one_current_limit_ma, .core_two_current_limit_ma, .conv_op_mode,
    .conv_pulldown_on, .conv_sense_mix, .conv_feedback_invalid, .core_one_mixer_off,
    .core_one_remote_diff_sense, .termination_mode_on, .termination_reference_on,
    .reference_port_comparator, .memory_sense_reports_input);

  always #50 sys_clk = ~sys_clk;

  task close_out;
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // The run needs about 220 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  function automatic logic [11:0] ma(input logic [3:0] c, input logic f);
    return (ILIM_BASE_MA + ILIM_STEP_MA * c) << f;
  endfunction : ma

  function automatic logic [1:0] op(input logic [1:0] p, input logic s);
    case (p)
      POLICY_AB:    return s ? OP_SLEEP : OP_SYNC;
      POLICY_SLEEP: return OP_SLEEP;
      POLICY_SYNC:  return OP_SYNC;
      default:      return OP_AUTO;
    endcase
  endfunction : op

  // Called just after a rising edge; returns at the edge ending the data phase
  task bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(ba(idx), 1'b1, d);
  endtask : wr

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 8'h00);
    `CHK(rd, e)
    `CHK({hreadyout, hresp}, 2'h2)
  endtask : rdchk

  // Register lands at the end of the data phase, outputs one edge later
  task settle;
    repeat (2) @(posedge sys_clk);
  endtask : settle

  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk(ba(IDX_CURRENT_LIM), 32'h0);
    rdchk(ba(IDX_CORE_TWO), 32'h1);
    rdchk(ba(IDX_CORE_ONE), 32'h1);
    rdchk(ba(IDX_GENERAL), 32'h1);
    `CHK(core_two_current_limit_ma, 12'h1f4)
    for (int k = 0; k < 16; k++)
    begin
      full_current_active <= k[0];
      wr(IDX_CURRENT_LIM, {k[3:0], ~k[3:0]});
      settle();
      `CHK(core_two_current_limit_ma, ma(k[3:0], k[0]))
      `CHK(core_one_current_limit_ma, ma(~k[3:0], k[0]))
      rdchk(ba(IDX_CURRENT_LIM), {24'h0, k[3:0], ~k[3:0]});
    end
    full_current_active <= 1'b0;
    for (int p = 0; p < 8; p++)
    begin
      sleep_select_a <= {3{p[0]}};
      wr(IDX_CORE_TWO, {p[2:1], 6'h01});
      wr(IDX_CORE_ONE, {p[2:1], 6'h01});
      wr(IDX_GENERAL, {p[2:1], 6'h01});
      settle();
      `CHK(conv_op_mode[1], op(p[2:1], p[0]))
      `CHK(conv_op_mode[0], op(p[2:1], p[0]))
      `CHK(conv_op_mode[2], op(p[2:1], p[0]))
    end
    wr(IDX_CORE_TWO, 8'hff);
    wr(IDX_CORE_ONE, 8'hff);
    wr(IDX_GENERAL, 8'hff);
    settle();
    rdchk(ba(IDX_CORE_TWO), 32'he7);
    rdchk(ba(IDX_CORE_ONE), 32'he7);
    rdchk(ba(IDX_GENERAL), 32'hff);
    `CHK(conv_pulldown_on, 3'h0)
    `CHK({termination_mode_on, termination_reference_on, reference_port_comparator}, 3'h6)
    `CHK(memory_sense_reports_input, 1'b0)
    wr(IDX_CORE_TWO, 8'h00);
    wr(IDX_CORE_ONE, 8'h00);
    wr(IDX_GENERAL, 8'h10);
    core_pair_merge <= 1'b1;
    settle();
    `CHK(conv_pulldown_on, 3'h7)
    `CHK(conv_feedback_invalid, 3'h6)
    `CHK({core_one_mixer_off, core_one_remote_diff_sense}, 2'h3)
    `CHK({termination_mode_on, memory_sense_reports_input}, 2'h3)
    rdchk(ba(IDX_STATUS), 32'h4e);
    dual_phase_active <= 1'b1;
    conv_enabled <= 3'h1;
    core_pair_merge <= 1'b0;
    wr(IDX_CORE_TWO, 8'h05);
    wr(IDX_CORE_ONE, 8'h06);
    settle();
    `CHK(conv_pulldown_on, 3'h4)
    `CHK(conv_sense_mix[1], 3'h5)
    `CHK(conv_sense_mix[0], 3'h6)
    `CHK({conv_feedback_invalid, core_one_mixer_off, core_one_remote_diff_sense}, 5'h10)
    // Unmapped slot and read-only status both ignore writes
    bus(12'h3fc, 1'b1, 8'haa);
    rdchk(12'h3fc, 32'h0);
    bus(ba(IDX_STATUS), 1'b1, 8'hff);
    rdchk(ba(IDX_STATUS), 32'h2c);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK({reference_port_comparator, memory_sense_reports_input}, 2'h3)
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk(ba(IDX_CORE_TWO), 32'h1);
    settle();
    `CHK(core_two_current_limit_ma, 12'h1f4)
    close_out();
  end
endmodule : testbench
